//--- rtl/haptic_cfg_pkg.sv
// Package: register map, field layout, reset values and timing counts
package haptic_cfg_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] CONTROL_FOUR_OFS     = 8'h1E;
    localparam logic [7:0] CONTROL_FIVE_OFS     = 8'h1F;
    localparam logic [7:0] OPEN_LOOP_PERIOD_OFS = 8'h20;
    localparam logic [7:0] SUPPLY_MONITOR_OFS   = 8'h21;
    localparam logic [7:0] NV_FIRST_OFS         = 8'h16;
    localparam logic [7:0] NV_LAST_OFS          = 8'h1A;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CAL_SEL_LSB      = 4;
    localparam int NV_DONE_BIT      = 2;
    localparam int NV_BURN_BIT      = 0;
    localparam int SYNC_LIMIT_LSB   = 6;
    localparam int AUTO_FALLBACK_BIT = 5;
    localparam int STEP_SEL_BIT     = 4;
    localparam int BLANK_HI_LSB     = 2;
    localparam int DISCH_HI_LSB     = 0;
    // ************************************************************
    // Reset values and write mask
    // ************************************************************
    localparam logic [7:0] CONTROL_FOUR_RST     = 8'h20;
    localparam logic [7:0] CONTROL_FIVE_RST     = 8'h80;
    localparam logic [7:0] OPEN_LOOP_PERIOD_RST = 8'h00;
    localparam logic [7:0] SUPPLY_MONITOR_RST   = 8'h00;
    localparam logic [7:0] CONTROL_FOUR_WMASK   = 8'hF1;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ        = 100_000_000;
    localparam int CAL0_MS       = 150;
    localparam int CAL1_MS       = 250;
    localparam int CAL2_MS       = 500;
    localparam int CAL3_MS       = 1000;
    localparam int STEP_SLOW_MS  = 5;
    localparam int STEP_FAST_MS  = 1;
    localparam int TICK_US       = 1;
    localparam int TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
    localparam int PERIOD_UNIT_NS = 98460;
    localparam int PERIOD_UNIT_CYC = PERIOD_UNIT_NS / 10;
    localparam int NV_BURN_CYC   = 16;
    localparam int SYNC_BASE     = 3;
endpackage

//--- rtl/haptic_ms_tick.sv
// Millisecond tick divider from the 1 us enable pulse
`timescale 1ns/1ps
module haptic_ms_tick
    import haptic_cfg_pkg::*;
#(
    parameter int US_PER_MS = 1000
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic us_tick_i,
    output logic      ms_tick_o
);
    logic [9:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q     <= 10'h000;
            ms_tick_o <= 1'b0;
        end else begin
            ms_tick_o <= 1'b0;
            if (us_tick_i) begin
                if (cnt_q == 10'(US_PER_MS - 1)) begin
                    cnt_q     <= 10'h000;
                    ms_tick_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 10'h001;
                end
            end
        end
    end
endmodule

//--- rtl/haptic_drive_config_regs.sv
// Configuration and monitor registers for the haptic drive engine
`timescale 1ns/1ps
module haptic_drive_config_regs
    import haptic_cfg_pkg::*;
#(
    parameter int US_PER_MS = 1000
) (
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    // Register access from the I2C slave engine
    input  wire logic       REG_WR_I,
    input  wire logic       REG_RD_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    output logic [7:0]      REG_RDATA_O,
    // Nonvolatile store
    input  wire logic [7:0] NV_SRC_DATA_I,
    output logic [7:0]      NV_SRC_ADDR_O,
    output logic            NV_WR_O,
    input  wire logic       NV_FUSED_I,
    // Drive engine
    input  wire logic       CAL_START_I,
    output logic            CAL_BUSY_O,
    input  wire logic       DRIVE_ACTIVE_I,
    input  wire logic       PLAYBACK_MODE_I,
    input  wire logic       BEMF_MISS_I,
    input  wire logic [7:0] SUPPLY_ADC_I,
    output logic            OPEN_LOOP_O,
    output logic            STEP_TICK_O,
    output logic            DRIVE_PHASE_O,
    output logic [1:0]      BLANK_HI_O,
    output logic [1:0]      DISCH_HI_O
);
    // ************************************************************
    // Registers
    // ************************************************************
    typedef enum {NV_IDLE, NV_COPY, NV_DONE} nv_state_t;
    logic [7:0] ctl4_q;
    logic [7:0] ctl5_q;
    logic [7:0] olp_q;
    logic [7:0] vmon_q;
    logic       nv_done_q;
    nv_state_t  nv_q;

    function automatic logic [2:0] sync_limit(input logic [1:0] code);
        sync_limit = 3'(SYNC_BASE) + {1'b0, code};
    endfunction

    function automatic logic [7:0] ctl4_view(input logic [7:0] r,
                                             input logic d);
        ctl4_view = (r & CONTROL_FOUR_WMASK)
                  | (8'(d) << NV_DONE_BIT);
    endfunction

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctl4_q <= CONTROL_FOUR_RST;
            ctl5_q <= CONTROL_FIVE_RST;
            olp_q  <= OPEN_LOOP_PERIOD_RST;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == CONTROL_FOUR_OFS) begin
                ctl4_q <= REG_WDATA_I & CONTROL_FOUR_WMASK;
            end else if (REG_ADDR_I == CONTROL_FIVE_OFS) begin
                ctl5_q <= REG_WDATA_I;
            end else if (REG_ADDR_I == OPEN_LOOP_PERIOD_OFS) begin
                olp_q <= REG_WDATA_I;
            end
        end else if (nv_q == NV_DONE) begin
            ctl4_q[NV_BURN_BIT] <= 1'b0;
        end
    end

    // Reading is frozen while drive is inactive, except for host writes, so host sees last good value
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            vmon_q <= SUPPLY_MONITOR_RST;
        end else if (REG_WR_I && REG_ADDR_I == SUPPLY_MONITOR_OFS) begin
            vmon_q <= REG_WDATA_I;
        end else if (DRIVE_ACTIVE_I) begin
            vmon_q <= SUPPLY_ADC_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_RD_I) begin
            if (REG_ADDR_I == CONTROL_FOUR_OFS) begin
                REG_RDATA_O <= ctl4_view(ctl4_q, nv_done_q);
            end else if (REG_ADDR_I == CONTROL_FIVE_OFS) begin
                REG_RDATA_O <= ctl5_q;
            end else if (REG_ADDR_I == OPEN_LOOP_PERIOD_OFS) begin
                REG_RDATA_O <= olp_q;
            end else if (REG_ADDR_I == SUPPLY_MONITOR_OFS) begin
                REG_RDATA_O <= vmon_q;
            end else begin
                REG_RDATA_O <= 8'h00;
            end
        end
    end

    // ************************************************************
    // Nonvolatile burn
    // ************************************************************
    // Fused flag from the store stops a reset reopening programming
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            nv_q          <= NV_IDLE;
            nv_done_q     <= 1'b0;
            NV_SRC_ADDR_O <= 8'h00;
            NV_WR_O       <= 1'b0;
        end else begin
            NV_WR_O <= 1'b0;
            case (nv_q)
                NV_IDLE: begin
                    if (NV_FUSED_I) begin
                        nv_done_q <= 1'b1;
                        nv_q      <= NV_DONE;
                    end else if (ctl4_q[NV_BURN_BIT] && !nv_done_q) begin
                        NV_SRC_ADDR_O <= NV_FIRST_OFS;
                        nv_q          <= NV_COPY;
                    end
                end
                NV_COPY: begin
                    NV_WR_O <= !NV_WR_O;
                    if (NV_WR_O && NV_SRC_ADDR_O == NV_LAST_OFS) begin
                        nv_done_q <= 1'b1;
                        nv_q      <= NV_DONE;
                    end else if (NV_WR_O) begin
                        NV_SRC_ADDR_O <= NV_SRC_ADDR_O + 8'h01;
                    end
                end
                default: begin
                    nv_done_q <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // Time base
    // ************************************************************
    logic [6:0]  us_cnt_q;
    logic        us_tick_q;
    logic        ms_tick;
    logic [2:0]  step_cnt_q;
    logic [10:0] cal_cnt_q;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            us_cnt_q  <= 7'h00;
            us_tick_q <= 1'b0;
        end else begin
            us_tick_q <= (us_cnt_q == 7'(TICK_CYC - 1));
            us_cnt_q  <= (us_cnt_q == 7'(TICK_CYC - 1)) ? 7'h00
                                                        : us_cnt_q + 7'h01;
        end
    end

    haptic_ms_tick #(.US_PER_MS(US_PER_MS)) u_ms (
        .clk_i     (CLK_I),
        .rst_i     (RST_I),
        .us_tick_i (us_tick_q),
        .ms_tick_o (ms_tick)
    );

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            step_cnt_q  <= 3'h0;
            STEP_TICK_O <= 1'b0;
        end else begin
            STEP_TICK_O <= 1'b0;
            if (ms_tick) begin
                if (step_cnt_q >= (ctl5_q[STEP_SEL_BIT]
                        ? 3'(STEP_FAST_MS - 1) : 3'(STEP_SLOW_MS - 1))) begin
                    step_cnt_q  <= 3'h0;
                    STEP_TICK_O <= 1'b1;
                end else begin
                    step_cnt_q <= step_cnt_q + 3'h1;
                end
            end
        end
    end

    // One spare tick: the first ms tick may come at once, minimum holds
    function automatic logic [10:0] cal_len(input logic [1:0] code);
        case (code)
            2'd0:    cal_len = 11'(CAL0_MS);
            2'd1:    cal_len = 11'(CAL1_MS);
            2'd2:    cal_len = 11'(CAL2_MS);
            default: cal_len = 11'(CAL3_MS);
        endcase
    endfunction

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cal_cnt_q  <= 11'h000;
            CAL_BUSY_O <= 1'b0;
        end else if (!CAL_BUSY_O && CAL_START_I) begin
            cal_cnt_q  <= cal_len(ctl4_q[CAL_SEL_LSB +: 2]) + 11'h001;
            CAL_BUSY_O <= 1'b1;
        end else if (CAL_BUSY_O && ms_tick) begin
            cal_cnt_q <= cal_cnt_q - 11'h001;
            if (cal_cnt_q == 11'h001) begin
                CAL_BUSY_O <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Open-loop fallback and drive period
    // ************************************************************
    logic [2:0]  miss_cnt_q;
    logic [19:0] per_cnt_q;
    logic [6:0]  half_cnt_q;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            miss_cnt_q  <= 3'h0;
            OPEN_LOOP_O <= 1'b0;
        end else if (!DRIVE_ACTIVE_I || !ctl5_q[AUTO_FALLBACK_BIT]) begin
            miss_cnt_q  <= 3'h0;
            OPEN_LOOP_O <= PLAYBACK_MODE_I && DRIVE_ACTIVE_I;
        end else if (BEMF_MISS_I && !OPEN_LOOP_O) begin
            miss_cnt_q <= miss_cnt_q + 3'h1;
            if (miss_cnt_q + 3'h1 >= sync_limit(ctl5_q[SYNC_LIMIT_LSB +: 2]))
            begin
                OPEN_LOOP_O <= 1'b1;
            end
        end
    end

    // Half of the period per phase; period value 0 stops toggling
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            per_cnt_q     <= 20'h00000;
            half_cnt_q    <= 7'h00;
            DRIVE_PHASE_O <= 1'b0;
        end else if (!OPEN_LOOP_O || olp_q[6:0] == 7'h00) begin
            per_cnt_q  <= 20'h00000;
            half_cnt_q <= 7'h00;
        end else if (per_cnt_q == 20'(PERIOD_UNIT_CYC / 2 - 1)) begin
            per_cnt_q <= 20'h00000;
            if (half_cnt_q == olp_q[6:0] - 7'h01) begin
                half_cnt_q    <= 7'h00;
                DRIVE_PHASE_O <= ~DRIVE_PHASE_O;
            end else begin
                half_cnt_q <= half_cnt_q + 7'h01;
            end
        end else begin
            per_cnt_q <= per_cnt_q + 20'h00001;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            BLANK_HI_O <= 2'b00;
            DISCH_HI_O <= 2'b00;
        end else begin
            BLANK_HI_O <= ctl5_q[BLANK_HI_LSB +: 2];
            DISCH_HI_O <= ctl5_q[DISCH_HI_LSB +: 2];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_rsv_zero;
        @(posedge CLK_I) disable iff (RST_I)
        REG_RD_I && REG_ADDR_I == CONTROL_FOUR_OFS |=>
            REG_RDATA_O[3] == 1'b0 && REG_RDATA_O[1] == 1'b0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved bit read nonzero");
    property p_nv_once;
        @(posedge CLK_I) disable iff (RST_I)
        nv_done_q |=> !NV_WR_O;
    endproperty
    a_nv_once: assert property (p_nv_once)
        else $error("second nonvolatile write");
    property p_nv_range;
        @(posedge CLK_I) disable iff (RST_I)
        NV_WR_O |-> NV_SRC_ADDR_O >= NV_FIRST_OFS
                 && NV_SRC_ADDR_O <= NV_LAST_OFS;
    endproperty
    a_nv_range: assert property (p_nv_range)
        else $error("burn address out of range");
    property p_nv_flag;
        @(posedge CLK_I) disable iff (RST_I)
        nv_done_q && REG_RD_I && REG_ADDR_I == CONTROL_FOUR_OFS
            |=> REG_RDATA_O[NV_DONE_BIT];
    endproperty
    a_nv_flag: assert property (p_nv_flag)
        else $error("programmed flag not shown");
    property p_no_fallback;
        @(posedge CLK_I) disable iff (RST_I)
        !ctl5_q[AUTO_FALLBACK_BIT] && !PLAYBACK_MODE_I |=> !OPEN_LOOP_O;
    endproperty
    a_no_fallback: assert property (p_no_fallback)
        else $error("fallback while disabled");
    property p_vmon_hold;
        @(posedge CLK_I) disable iff (RST_I)
        !DRIVE_ACTIVE_I && !REG_WR_I |=> $stable(vmon_q);
    endproperty
    a_vmon_hold: assert property (p_vmon_hold)
        else $error("supply reading moved while idle");
    property p_blank;
        @(posedge CLK_I) disable iff (RST_I)
        ##1 BLANK_HI_O == $past(ctl5_q[BLANK_HI_LSB +: 2])
            && DISCH_HI_O == $past(ctl5_q[DISCH_HI_LSB +: 2]);
    endproperty
    a_blank: assert property (p_blank)
        else $error("time MSBs wrong");
    property p_step_fast;
        @(posedge CLK_I) disable iff (RST_I)
        ctl5_q[STEP_SEL_BIT] && ms_tick && step_cnt_q == 3'h0 |=> STEP_TICK_O;
    endproperty
    a_step_fast: assert property (p_step_fast)
        else $error("fast step tick missing");
    c_burn:     cover property (@(posedge CLK_I) nv_q == NV_COPY);
    c_fallback: cover property (@(posedge CLK_I) $rose(OPEN_LOOP_O));
    c_cal_done: cover property (@(posedge CLK_I) $fell(CAL_BUSY_O));
endmodule

//--- verif/haptic_host_model.sv
// Host model: strobe-bus register master standing in for the I2C engine
`timescale 1ns/1ps
module haptic_host_model (
    input  wire logic       clk_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    input  wire logic [7:0] rdata_i
);
    // ************************************************************
    // Bus cycles
    // ************************************************************
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // Released lines show the inverse so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        rd_o = 1'b1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
endmodule

//--- verif/haptic_drive_config_regs_tb.sv
// Self-checking bench for the haptic drive configuration registers
`timescale 1ns/1ps
module haptic_drive_config_regs_tb import haptic_cfg_pkg::*;;
    localparam int US_MS  = 1;
    localparam int MS_CYC = US_MS * TICK_CYC;
    logic       clk       = 1'b0;
    logic       rst       = 1'b1;
    logic       fused     = 1'b0;
    logic       cal_start = 1'b0;
    logic       drv       = 1'b0;
    logic       pbm       = 1'b0;
    logic       miss      = 1'b0;
    logic [7:0] adc       = 8'h00;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] nv_addr;
    logic       nv_wr;
    logic       busy;
    logic       ol;
    logic       step;
    logic       phase;
    logic [1:0] blank;
    logic [1:0] disch;
    int         error_cnt = 0;
    int         samples_checked = 0;

    always #5 clk = ~clk;

    haptic_host_model host_u (.clk_i(clk), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));

    haptic_drive_config_regs #(.US_PER_MS(US_MS)) dut_u (
        .CLK_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .NV_SRC_DATA_I(8'h00), .NV_SRC_ADDR_O(nv_addr), .NV_WR_O(nv_wr),
        .NV_FUSED_I(fused), .CAL_START_I(cal_start), .CAL_BUSY_O(busy),
        .DRIVE_ACTIVE_I(drv), .PLAYBACK_MODE_I(pbm), .BEMF_MISS_I(miss),
        .SUPPLY_ADC_I(adc), .OPEN_LOOP_O(ol), .STEP_TICK_O(step),
        .DRIVE_PHASE_O(phase), .BLANK_HI_O(blank), .DISCH_HI_O(disch));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Counts sampled cycles until the signal shows the wanted level
    task automatic till(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 200000) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic pulse(ref logic s);
        cyc(1);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    task automatic do_reset;
        cyc(1);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        logic [7:0] d;
        logic [7:0] ofs [5] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22};
        logic [7:0] exp [5] = '{8'h20, 8'h80, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            host_u.rd(ofs[i], d);
            chk(d, exp[i]);
        end
        $display("reset values done");
    endtask

    task automatic t_fields;
        logic [7:0] d;
        logic [7:0] v;
        host_u.wr(CONTROL_FOUR_OFS, 8'hFA);
        host_u.rd(CONTROL_FOUR_OFS, d);
        chk(d, 8'hF0);
        for (int i = 0; i < 4; i++) begin
            v = {4'h8, i[1:0], ~i[1:0]};
            host_u.wr(CONTROL_FIVE_OFS, v);
            cyc(1);
            chk(blank, v[3:2]);
            chk(disch, v[1:0]);
        end
        $display("field layout done");
    endtask

    // The host trusts the reading only while a waveform plays
    task automatic t_supply;
        logic [7:0] d;
        adc = 8'h5A;
        cyc(3);
        host_u.rd(SUPPLY_MONITOR_OFS, d);
        chk(d, 8'h00);
        drv = 1'b1;
        cyc(3);
        host_u.rd(SUPPLY_MONITOR_OFS, d);
        chk(d, 8'h5A);
        drv = 1'b0;
        adc = 8'hC3;
        cyc(3);
        host_u.rd(SUPPLY_MONITOR_OFS, d);
        chk(d, 8'h5A);
        host_u.wr(SUPPLY_MONITOR_OFS, 8'h3C);
        host_u.rd(SUPPLY_MONITOR_OFS, d);
        chk(d, 8'h3C);
        $display("supply monitor done");
    endtask

    task automatic t_fallback;
        for (int c = 0; c < 4; c++) begin
            do_reset();
            host_u.wr(CONTROL_FIVE_OFS, {c[1:0], 6'h20});
            drv = 1'b1;
            for (int k = 1; k < 3 + c; k++) begin
                pulse(miss);
            end
            cyc(3);
            chk(ol, 1'b0);
            pulse(miss);
            cyc(3);
            chk(ol, 1'b1);
            drv = 1'b0;
        end
        do_reset();
        host_u.wr(CONTROL_FIVE_OFS, 8'hC0);
        drv = 1'b1;
        repeat (8) pulse(miss);
        cyc(3);
        chk(ol, 1'b0);
        pbm = 1'b1;
        cyc(3);
        chk(ol, 1'b1);
        $display("fallback done");
    endtask

    // Bit 7 of the period register must not stretch the period
    task automatic t_phase;
        logic [7:0] d;
        int n;
        host_u.wr(OPEN_LOOP_PERIOD_OFS, 8'h81);
        host_u.rd(OPEN_LOOP_PERIOD_OFS, d);
        chk(d, 8'h81);
        till(phase, ~phase, n);
        till(phase, ~phase, n);
        chk(n, 98460 / 20);
        pbm = 1'b0;
        $display("open-loop period done");
    endtask

    task automatic t_step;
        int n;
        int m;
        for (int s = 0; s < 2; s++) begin
            host_u.wr(CONTROL_FIVE_OFS, {3'h4, s[0], 4'h0});
            till(step, 1'b1, n);
            till(step, 1'b0, n);
            till(step, 1'b1, m);
            chk(n + m, (s == 1 ? 1 : 5) * MS_CYC);
        end
        drv = 1'b0;
        $display("playback step done");
    endtask

    task automatic t_burn;
        logic [7:0] d;
        int n;
        host_u.wr(CONTROL_FOUR_OFS, 8'h21);
        for (int k = 0; k < 5; k++) begin
            till(nv_wr, 1'b1, n);
            chk(nv_addr, 8'h16 + k);
            till(nv_wr, 1'b0, n);
        end
        cyc(20);
        host_u.rd(CONTROL_FOUR_OFS, d);
        chk(d, 8'h24);
        fused = 1'b1;
        do_reset();
        host_u.wr(CONTROL_FOUR_OFS, 8'h21);
        n = 0;
        repeat (100) begin
            cyc(1);
            if (nv_wr !== 1'b0) begin
                n++;
            end
        end
        chk(n, 0);
        host_u.rd(CONTROL_FOUR_OFS, d);
        chk(d, 8'h24);
        $display("nonvolatile burn done");
    endtask

    task automatic t_cal;
        int n;
        host_u.wr(CONTROL_FOUR_OFS, 8'h20);
        pulse(cal_start);
        till(busy, 1'b1, n);
        till(busy, 1'b0, n);
        chk(n >= 500 * MS_CYC && n <= 700 * MS_CYC, 1'b1);
        $display("calibration done");
    endtask

    // ************************************************************
    // Sequence and watchdog
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_fields();
        t_supply();
        t_fallback();
        t_phase();
        t_step();
        t_burn();
        t_cal();
        final_report();
    end

    // About 62k cycles of tests; give up at 100k
    initial begin
        #1_000_000;
        error_cnt++;
        final_report();
    end
endmodule
